// File: hw/reset_seq_pkg.sv
// constants, types and field layout of the reset timeout sequencer
//------------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------------
package reset_seq_pkg;

	//------------------------------------------------------------
	// timing
	//------------------------------------------------------------
	localparam int CLK_NS          = 100;
	localparam int RC_TICK_NS      = 1000;
	localparam int RC_TICK_CYCLES  = RC_TICK_NS / CLK_NS;
	localparam int POWER_UP_TIMER_TIME_MS    = 72;
	localparam int PLL_TIME_MS     = 2;
	localparam int POWER_UP_TIMER_TICKS      = POWER_UP_TIMER_TIME_MS * 1000000 / RC_TICK_NS;
	localparam int PLL_TICKS       = PLL_TIME_MS * 1000000 / RC_TICK_NS;
	localparam int OST_EDGES       = 1024;
	localparam int EC_REC_NS       = 1500;
	localparam int EC_REC_CYCLES   = (EC_REC_NS + CLK_NS - 1) / CLK_NS;
	localparam int BOR_QUAL_CYCLES = 20;
	localparam int TMR_W           = 17;

	//------------------------------------------------------------
	// register map
	//------------------------------------------------------------
	localparam logic [7:0] RCS_OFFSET   = 8'h00;
	localparam logic [7:0] CTRL_OFFSET  = 8'h04;
	localparam logic [7:0] STATE_OFFSET = 8'h08;
	localparam int RCS_IRQ_PRIORITY_ENABLE_BIT = 7;
	localparam int RCS_RI_BIT   = 4;
	localparam int RCS_TO_BIT   = 3;
	localparam int RCS_PD_BIT   = 2;
	localparam int RCS_POR_BIT  = 1;
	localparam int RCS_BOR_BIT  = 0;
	localparam int CTRL_SWRST_BIT = 0;
	localparam logic [7:0] RCS_IMPL_MASK = 8'h9F;
	localparam logic [7:0] RCS_POR_VALUE = 8'h1C;
	localparam logic [7:0] RCS_BOR_VALUE = 8'h1E;

	//------------------------------------------------------------
	// program counter targets
	//------------------------------------------------------------
	localparam logic [20:0] VEC_RESET = 21'h000000;
	localparam logic [20:0] VEC_HIGH  = 21'h000008;
	localparam logic [20:0] VEC_LOW   = 21'h000018;

	//------------------------------------------------------------
	// types
	//------------------------------------------------------------
	typedef enum logic [2:0] {
		crystal_low_power_mode,
		crystal_mid_mode,
		crystal_high_speed_mode,
		external_clock_mode,
		external_rc_mode
	} osc_mode_t;

	typedef struct packed {
		osc_mode_t osc_mode;
		logic      pll_enable;
		logic      power_up_timer_enable_n;
		logic      brownout_enable_cfg;
	} fuse_cfg_t;

	typedef struct packed {
		logic sleep_enter;
		logic wdt_event;
		logic irq_wake;
		logic irq_high;
		logic global_irq_enable_high;
		logic global_irq_enable_low;
	} core_evt_t;

	typedef enum logic [1:0] {
		pc_reset,
		pc_next,
		pc_vector
	} pc_action_t;

	typedef struct packed {
		pc_action_t  action;
		logic [20:0] vector;
	} pc_cmd_t;

	typedef enum logic [2:0] {
		st_supply_wait,
		st_power_up_timer,
		st_ost,
		st_pll,
		st_recover,
		st_run,
		st_sleep
	} seq_state_t;

endpackage

// File: hw/reset_timeout_sequencer.sv
// reset timeout sequencer with cause status register on wishbone
`timescale 1ns/1ns
module reset_timeout_sequencer import reset_seq_pkg::*; #(
	parameter int POWER_UP_TIMER_LIMIT = POWER_UP_TIMER_TICKS,
	parameter int PLL_LIMIT  = PLL_TICKS
) (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	// wishbone slave
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [7:0]  i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic             o_wb_ack,
	output logic      [31:0] o_wb_dat,
	// pins and detectors
	input  wire logic        i_master_clear_n,
	input  wire logic        i_osc_input_pin,
	input  wire logic        i_low_supply,
	// configuration and core events
	input  wire fuse_cfg_t   i_cfg,
	input  wire core_evt_t   i_evt,
	// core control
	output logic             o_core_reset,
	output logic             o_core_hold,
	output logic             o_pc_load,
	output pc_cmd_t          o_pc,
	output logic             o_irq_priority_enable
);

	//------------------------------------------------------------
	// state
	//------------------------------------------------------------
	seq_state_t             state;
	seq_state_t             next_state;
	logic [TMR_W-1:0]       tmr;
	logic [TMR_W-1:0]       next_tmr;
	logic [3:0]             rc_div;
	logic [7:0]             bor_cnt;
	logic [7:0]             next_bor_cnt;
	logic [7:0]             rcs;
	logic [7:0]             next_rcs;
	logic                   wake_path;
	pc_cmd_t                resume;
	pc_cmd_t                next_resume;
	logic                   master_clear_n_s1;
	logic                   master_clear_n_s2;
	logic                   master_clear_n_d;
	logic                   osc_s1;
	logic                   osc_s2;
	logic                   osc_d;
	logic                   low_s1;
	logic                   low_s2;

	//------------------------------------------------------------
	// input synchronisers
	//------------------------------------------------------------
	// master clear pin is only read here, never driven
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			{master_clear_n_s1, master_clear_n_s2, master_clear_n_d} <= 3'h7;
			{osc_s1, osc_s2, osc_d}    <= 3'h0;
			{low_s1, low_s2}           <= 2'h3;
		end else begin
			{master_clear_n_s1, master_clear_n_s2, master_clear_n_d} <= {i_master_clear_n, master_clear_n_s1, master_clear_n_s2};
			{osc_s1, osc_s2, osc_d}    <= {i_osc_input_pin, osc_s1, osc_s2};
			{low_s1, low_s2}           <= {i_low_supply, low_s1};
		end
	end

	wire master_clear_n_fall = master_clear_n_d & ~master_clear_n_s2;
	wire master_clear_n_rise = ~master_clear_n_d & master_clear_n_s2;
	wire osc_rise  = ~osc_d & osc_s2;

	//------------------------------------------------------------
	// decode
	//------------------------------------------------------------
	wire is_crystal = (i_cfg.osc_mode == crystal_low_power_mode) |
		(i_cfg.osc_mode == crystal_mid_mode) |
		(i_cfg.osc_mode == crystal_high_speed_mode);
	wire is_ec     = i_cfg.osc_mode == external_clock_mode;
	wire in_sleep  = state == st_sleep;
	wire in_run    = state == st_run;
	wire in_timer  = (state == st_power_up_timer) | (state == st_ost) |
		(state == st_pll) | (state == st_recover);
	wire bus_req   = i_wb_cyc & i_wb_stb & ~o_wb_ack;
	wire bus_wr    = bus_req & i_wb_we & i_wb_sel[0];
	wire rcs_wr    = bus_wr & (i_wb_adr == RCS_OFFSET);
	wire sw_req    = bus_wr & (i_wb_adr == CTRL_OFFSET) &
		i_wb_dat[CTRL_SWRST_BIT] & in_run;
	wire bor_trip  = bor_cnt == 8'(BOR_QUAL_CYCLES);
	wire bor_evt   = bor_trip & (state != st_supply_wait);
	wire wake_any  = i_evt.wdt_event | i_evt.irq_wake | master_clear_n_fall;
	wire reset_evt = in_run & (sw_req | i_evt.wdt_event);
	wire rc_tick   = rc_div == 4'(RC_TICK_CYCLES - 1);

	// crystal start-up only on power or wake path
	seq_state_t wake_start;
	seq_state_t power_start;
	seq_state_t after_power_up_timer;
	seq_state_t after_ost;
	assign wake_start  = is_crystal ? st_ost :
		(is_ec ? st_recover : st_run);
	assign power_start = i_cfg.power_up_timer_enable_n ? wake_start :
		st_power_up_timer;
	assign after_power_up_timer  = is_crystal ? st_ost : st_run;
	assign after_ost   = i_cfg.pll_enable ? st_pll : st_run;

	//------------------------------------------------------------
	// shared timer
	//------------------------------------------------------------
	logic [TMR_W-1:0] tmr_limit;
	logic             tmr_inc;
	assign tmr_limit = (state == st_power_up_timer) ? TMR_W'(POWER_UP_TIMER_LIMIT) :
		(state == st_pll) ? TMR_W'(PLL_LIMIT) :
		(state == st_ost) ? TMR_W'(OST_EDGES) : TMR_W'(EC_REC_CYCLES);
	// power-up and pll delays count rc ticks
	assign tmr_inc = ((state == st_power_up_timer) | (state == st_pll)) ? rc_tick :
		(state == st_ost) ? osc_rise :
		(state == st_recover);
	wire tmr_done = tmr == tmr_limit;
	assign next_tmr = (next_state != state) ? '0 :
		tmr + {{(TMR_W - 1){1'b0}}, tmr_inc};

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rc_div <= 4'h0;
			tmr    <= '0;
		end else begin
			rc_div <= rc_tick ? 4'h0 : rc_div + 4'h1;
			tmr    <= next_tmr;
		end
	end

	//------------------------------------------------------------
	// brown-out qualification
	//------------------------------------------------------------
	// disabled brown-out keeps the count at zero
	assign next_bor_cnt = ~(low_s2 & i_cfg.brownout_enable_cfg) ? 8'h00 :
		bor_trip ? bor_cnt : bor_cnt + 8'h01;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			bor_cnt <= 8'h00;
		else
			bor_cnt <= next_bor_cnt;
	end

	//------------------------------------------------------------
	// sequencer
	//------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			st_supply_wait: if (!low_s2) next_state = power_start;
			st_power_up_timer:        if (tmr_done) next_state = after_power_up_timer;
			st_ost:         if (tmr_done) next_state = after_ost;
			st_pll:         if (tmr_done) next_state = st_run;
			st_recover:     if (tmr_done) next_state = st_run;
			st_run:         if (i_evt.sleep_enter) next_state = st_sleep;
			st_sleep:       if (wake_any) next_state = wake_start;
			default:        next_state = st_supply_wait;
		endcase
		// brown-out aborts any phase and restarts timers
		if (bor_trip)
			next_state = st_supply_wait;
	end

	// power-on enters the supply wait first
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			state <= st_supply_wait;
		else
			state <= next_state;
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			wake_path <= 1'b0;
		else if (bor_trip)
			wake_path <= 1'b0;
		else if (in_sleep & wake_any)
			wake_path <= ~master_clear_n_fall;
	end

	//------------------------------------------------------------
	// core control
	//------------------------------------------------------------
	// timers run whatever the pin does
	wire next_core_reset = ~master_clear_n_s2 | (state == st_supply_wait) |
		(in_timer & ~wake_path) | reset_evt | bor_trip;
	wire next_core_hold  = in_sleep | (in_timer & wake_path);
	wire entering_run    = (next_state == st_run) & ~in_run;
	wire irq_vec_ok      = i_evt.irq_high ? i_evt.global_irq_enable_high :
		i_evt.global_irq_enable_low;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_core_reset <= 1'b1;
			o_core_hold  <= 1'b0;
		end else begin
			o_core_reset <= next_core_reset;
			o_core_hold  <= next_core_hold;
		end
	end

	// resets restart at zero, wakes continue or vector
	// fresh target used directly when a wake goes straight to run
	always_comb begin
		next_resume = resume;
		if (bor_trip | (in_sleep & master_clear_n_fall))
			next_resume = pc_cmd_t'{pc_reset, VEC_RESET};
		else if (in_sleep & i_evt.wdt_event)
			next_resume = pc_cmd_t'{pc_next, VEC_RESET};
		else if (in_sleep & i_evt.irq_wake & irq_vec_ok)
			next_resume = pc_cmd_t'{pc_vector,
				i_evt.irq_high ? VEC_HIGH : VEC_LOW};
		else if (in_sleep & i_evt.irq_wake)
			next_resume = pc_cmd_t'{pc_next, VEC_RESET};
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			resume <= '{pc_reset, VEC_RESET};
		else
			resume <= next_resume;
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_pc_load <= 1'b0;
			o_pc      <= '{pc_reset, VEC_RESET};
		end else begin
			o_pc_load <= entering_run | reset_evt | (in_run & master_clear_n_rise);
			o_pc      <= entering_run ? next_resume : '{pc_reset, VEC_RESET};
		end
	end

	//------------------------------------------------------------
	// cause status register
	//------------------------------------------------------------
	// hardware events follow the bus write so that they win
	always_comb begin
		next_rcs = rcs;
		if (rcs_wr)
			next_rcs = i_wb_dat[7:0] & RCS_IMPL_MASK;
		if (in_run & master_clear_n_fall)
			next_rcs[RCS_IRQ_PRIORITY_ENABLE_BIT] = 1'b0;
		if (sw_req) begin
			next_rcs[RCS_IRQ_PRIORITY_ENABLE_BIT] = 1'b0;
			next_rcs[RCS_RI_BIT]   = 1'b0;
		end
		// timeout and power-down per cause
		if (in_run & i_evt.wdt_event) begin
			next_rcs[RCS_IRQ_PRIORITY_ENABLE_BIT] = 1'b0;
			next_rcs[RCS_TO_BIT]   = 1'b0;
			next_rcs[RCS_PD_BIT]   = 1'b1;
		end else if (in_sleep & i_evt.wdt_event) begin
			next_rcs[RCS_TO_BIT] = 1'b0;
			next_rcs[RCS_PD_BIT] = 1'b0;
		end else if (in_sleep & master_clear_n_fall) begin
			next_rcs[RCS_IRQ_PRIORITY_ENABLE_BIT] = 1'b0;
			next_rcs[RCS_TO_BIT]   = 1'b1;
			next_rcs[RCS_PD_BIT]   = 1'b0;
		end else if (in_sleep & i_evt.irq_wake) begin
			next_rcs[RCS_TO_BIT] = 1'b1;
			next_rcs[RCS_PD_BIT] = 1'b0;
		end
		if (bor_evt)
			next_rcs = RCS_BOR_VALUE;
	end

	// power-on value of the flags
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			rcs <= RCS_POR_VALUE;
		else
			rcs <= next_rcs;
	end

	assign o_irq_priority_enable = rcs[RCS_IRQ_PRIORITY_ENABLE_BIT];

	//------------------------------------------------------------
	// bus read and acknowledge
	//------------------------------------------------------------
	wire [31:0] rd_data = (i_wb_adr == RCS_OFFSET) ? {24'h000000, rcs} :
		(i_wb_adr == STATE_OFFSET) ? {26'h0000000, wake_path, state,
		o_core_hold, o_core_reset} : 32'h00000000;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h00000000;
		end else begin
			o_wb_ack <= bus_req;
			o_wb_dat <= bus_req ? rd_data : 32'h00000000;
		end
	end

	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	a_power_up_timer_holds_reset: assert property (
		state == st_power_up_timer |=> o_core_reset)
		else $error("core left reset during power-up timer");
	a_ost_follows_power_up_timer: assert property (
		(state == st_power_up_timer) && tmr_done && !bor_trip && is_crystal
		|=> state == st_ost && tmr == '0)
		else $error("start-up timer did not follow power-up timer");
	a_ost_crystal_only: assert property (
		$rose(state == st_ost) |-> $past(is_crystal))
		else $error("start-up timer run outside crystal mode");
	a_pll_after_ost: assert property (
		(state == st_ost) && tmr_done && !bor_trip && i_cfg.pll_enable
		|=> state == st_pll)
		else $error("pll lock delay skipped");
	a_bor_disabled: assert property (
		!i_cfg.brownout_enable_cfg |=> !bor_trip ##1 !bor_trip)
		else $error("brown-out tripped while disabled");
	a_bor_holds: assert property (
		bor_trip |=> state == st_supply_wait ##1 o_core_reset)
		else $error("brown-out did not hold reset");
	a_power_up_timer_restart: assert property (
		(state == st_power_up_timer) && bor_trip
		|=> state == st_supply_wait && tmr == '0)
		else $error("power-up timer not reinitialised");
	a_rc_no_delay: assert property (
		(state == st_supply_wait) && !low_s2 && !bor_trip &&
		i_cfg.osc_mode == external_rc_mode &&
		i_cfg.power_up_timer_enable_n |=> state == st_run && o_pc_load)
		else $error("rc mode applied a time-out");
	a_ec_recover_len: assert property (
		$rose(state == st_recover) && is_ec
		|-> (state == st_recover && !bor_trip)[*8] ##1 state == st_recover)
		else $error("recovery delay too short");
	a_sw_flag: assert property (
		sw_req && !bor_evt |=> !rcs[RCS_RI_BIT] && !o_irq_priority_enable)
		else $error("software reset flag not cleared");
	a_wdt_flags: assert property (
		in_run && i_evt.wdt_event && !bor_evt
		|=> !rcs[RCS_TO_BIT] && rcs[RCS_PD_BIT] && o_core_reset)
		else $error("watchdog reset flags wrong");

endmodule

// File: tb/supply_model.sv
// partner model: supply detector, master clear pin, crystal
`timescale 1ns/1ns
module supply_model (
	// bench controls
	input  wire logic i_clk,
	input  wire logic i_sag,
	input  wire logic i_press,
	// lines to the device
	output logic      o_low_supply,
	output logic      o_master_clear_n,
	output logic      o_osc_input_pin
);
	//--------------------------------------------------------
	// pins
	//--------------------------------------------------------
	logic [1:0] div;
	initial div = 2'h0;
	initial o_osc_input_pin = 1'b0;
	// detector reports low supply as long as it lasts
	assign o_low_supply     = i_sag;
	// pin pulled up unless the controller holds it low
	assign o_master_clear_n = !i_press;
	// crystal at an eighth of the clock
	always @(posedge i_clk) begin
		div <= div + 2'h1;
		if (div == 2'h3)
			o_osc_input_pin <= !o_osc_input_pin;
	end
endmodule

// File: tb/reset_timeout_sequencer_test.sv
// self-checking bench of the reset timeout sequencer
`timescale 1ns/1ns
module reset_timeout_sequencer_test import reset_seq_pkg::*;;
	localparam int P = 20 * RC_TICK_CYCLES;
	localparam int L = 5 * RC_TICK_CYCLES;
	localparam int O = (OST_EDGES - 1) * 8;
	logic        clk, rstn, cyc, stb, we, ack;
	logic [7:0]  adr;
	logic [31:0] wd, rdat;
	logic        sag, press, low, mcn, osc;
	logic        crst, hold, pld, ipe;
	fuse_cfg_t   cfg;
	core_evt_t   evt;
	pc_cmd_t     pc;
	int          bad_count, n_checks;
	int          n_loads = 0;
	int          ld_seen = 0;
	pc_cmd_t     last_pc;
	fuse_cfg_t   tc[6];
	int          tlo[6];

	reset_timeout_sequencer #(.POWER_UP_TIMER_LIMIT(20), .PLL_LIMIT(5)) DUT (
		.i_clk(clk), .i_resetn(rstn), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wd),
		.o_wb_ack(ack), .o_wb_dat(rdat), .i_master_clear_n(mcn),
		.i_osc_input_pin(osc), .i_low_supply(low), .i_cfg(cfg),
		.i_evt(evt), .o_core_reset(crst), .o_core_hold(hold),
		.o_pc_load(pld), .o_pc(pc), .o_irq_priority_enable(ipe));

	supply_model far_side (.i_clk(clk), .i_sag(sag), .i_press(press),
		.o_low_supply(low), .o_master_clear_n(mcn),
		.o_osc_input_pin(osc));

	always #50 clk = !clk;

	// load pulses counted so a pulse inside a bus call is not lost
	always @(posedge clk) begin
		if (pld === 1'b1) begin
			n_loads <= n_loads + 1;
			last_pc <= pc;
		end
	end

	//--------------------------------------------------------
	// shared tasks
	//--------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h expected %h",
				$time, got, exp);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a,
			input logic [7:0] d, output logic [31:0] r);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		wd  <= {24'h000000, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		r = rdat;
		chk({31'h0, ack}, 32'h1);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
		logic [31:0] r;
		wb(1'b0, a, 8'h00, r);
		chk(r & m, e);
	endtask

	task automatic wr(input logic [7:0] a, d);
		logic [31:0] r;
		wb(1'b1, a, d, r);
	endtask

	task automatic pulse(input logic [5:0] e);
		evt <= core_evt_t'(e);
		@(posedge clk);
		evt <= '0;
	endtask

	task automatic nap(input logic [5:0] e);
		pulse(6'h20);
		repeat (3) @(posedge clk);
		chk({31'h0, hold}, 32'h1);
		pulse(e);
	endtask

	task automatic pcw(input int lo, hi, input pc_action_t a,
			input logic [20:0] v);
		int n;
		n = 0;
		while (n_loads == ld_seen && n <= hi) begin
			@(posedge clk);
			n++;
		end
		ld_seen = n_loads;
		chk({31'h0, n >= lo && n <= hi}, 32'h1);
		chk(32'(last_pc.action), 32'(a));
		if (a != pc_next)
			chk({11'h000, last_pc.vector}, {11'h000, v});
		repeat (3) @(posedge clk);
		chk({30'h0, crst, hold}, 32'h0);
	endtask

	task automatic por(input fuse_cfg_t c);
		rstn <= 1'b0;
		cfg  <= c;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	//--------------------------------------------------------
	// main sequence
	//--------------------------------------------------------
	initial begin
		tc[0] = '{crystal_high_speed_mode, 1'b1, 1'b0, 1'b1};
		tc[1] = '{crystal_mid_mode, 1'b0, 1'b0, 1'b1};
		tc[2] = '{crystal_low_power_mode, 1'b0, 1'b1, 1'b1};
		tc[3] = '{external_clock_mode, 1'b0, 1'b1, 1'b0};
		tc[4] = '{external_rc_mode, 1'b0, 1'b1, 1'b1};
		tc[5] = '{external_rc_mode, 1'b0, 1'b0, 1'b1};
		tlo = '{P + O + L - 20, P + O - 10, O, EC_REC_CYCLES, 0, P - 10};
		clk = 1'b0;
		rstn = 1'b0;
		{cyc, stb, we, sag, press} = 5'h00;
		adr = 8'h00;
		wd = 32'h0;
		evt = '0;
		cfg = tc[0];
		bad_count = 0;
		n_checks = 0;
		for (int i = 0; i < 6; i++) begin
			por(tc[i]);
			pcw(tlo[i], tlo[i] + 40, pc_reset, VEC_RESET);
			rd(RCS_OFFSET, 32'hFF, 32'(RCS_POR_VALUE));
			if (!tc[i].brownout_enable_cfg) begin
				sag <= 1'b1;
				repeat (40) @(posedge clk);
				chk({31'h0, crst}, 32'h0);
				sag <= 1'b0;
			end
		end
		rd(8'h10, 32'hFFFFFFFF, 32'h0);
		wr(RCS_OFFSET, 8'hFF);
		rd(RCS_OFFSET, 32'hFFFFFFFF, 32'h9F);
		chk({31'h0, ipe}, 32'h1);
		wr(RCS_OFFSET, 8'h1F);
		wr(CTRL_OFFSET, 8'h01);
		pcw(0, 20, pc_reset, VEC_RESET);
		rd(RCS_OFFSET, 32'hFF, 32'h0F);
		nap(6'h0E);
		pcw(0, 20, pc_vector, VEC_HIGH);
		rd(RCS_OFFSET, 32'hFF, 32'h0B);
		nap(6'h09);
		pcw(0, 20, pc_vector, VEC_LOW);
		nap(6'h10);
		pcw(0, 20, pc_next, VEC_RESET);
		rd(RCS_OFFSET, 32'h0C, 32'h00);
		pulse(6'h10);
		pcw(0, 20, pc_reset, VEC_RESET);
		rd(RCS_OFFSET, 32'h0C, 32'h04);
		// brown-out: short dip, trip, dip during power-up timer
		sag <= 1'b1;
		repeat (10) @(posedge clk);
		sag <= 1'b0;
		repeat (10) @(posedge clk);
		chk({31'h0, crst}, 32'h0);
		sag <= 1'b1;
		repeat (40) @(posedge clk);
		chk({31'h0, crst}, 32'h1);
		rd(RCS_OFFSET, 32'hFF, 32'(RCS_BOR_VALUE));
		sag <= 1'b0;
		repeat (100) @(posedge clk);
		chk({31'h0, crst}, 32'h1);
		sag <= 1'b1;
		repeat (40) @(posedge clk);
		sag <= 1'b0;
		pcw(P - 10, P + 40, pc_reset, VEC_RESET);
		// master clear held through the power-up time-outs
		press <= 1'b1;
		repeat (8) @(posedge clk);
		chk({31'h0, crst}, 32'h1);
		por(tc[5]);
		repeat (P + 60) @(posedge clk);
		chk({31'h0, crst}, 32'h1);
		press <= 1'b0;
		repeat (8) @(posedge clk);
		chk({31'h0, crst}, 32'h0);
		end_of_test();
	end

	//--------------------------------------------------------
	// watchdog
	//--------------------------------------------------------
	initial begin
		repeat (60000) @(posedge clk);
		bad_count++;
		end_of_test();
	end
endmodule
